/* File: rtl/pmc_pkg.sv */
// Purpose: Constants for the port 0 mode control block
// Assumes: Byte-wide internal bus, 25 MHz system clock
// Notes: Pins are numbered 1 to 5; bit 0 of the port does not exist
package pmc_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [31:0] PMC_ADDR_FUNC_SEL = 32'hffff_f440;
	localparam logic [31:0] PMC_ADDR_ALT_CHOICE = 32'hffff_f460;
	localparam logic [31:0] PMC_ADDR_PORT_DATA = 32'hffff_f400;
	localparam logic [31:0] PMC_ADDR_DIRECTION = 32'hffff_f420;
	localparam logic [7:0] PMC_FUNC_SEL_RST = 8'h00;
	localparam logic [7:0] PMC_ALT_CHOICE_RST = 8'h00;
	localparam logic [7:0] PMC_PORT_DATA_RST = 8'h00;
	localparam logic [7:0] PMC_DIRECTION_RST = 8'hff;
	localparam logic [7:0] PMC_FUNC_SEL_MASK = 8'h3e;
	localparam logic [7:0] PMC_ALT_CHOICE_MASK = 8'h30;
	localparam logic [7:0] PMC_PORT_MASK = 8'h3e;
	// ----------------------------------------
	// Bit positions
	// ----------------------------------------
	localparam int PMC_BIT_TI = 1;
	localparam int PMC_BIT_IRQ_A1 = 2;
	localparam int PMC_BIT_TO = 3;
	localparam int PMC_BIT_B0 = 4;
	localparam int PMC_BIT_B1 = 5;
	// ----------------------------------------
	// Noise filter
	// ----------------------------------------
	localparam int PMC_FILT_NS = 120;
	localparam int PMC_CLK_NS = 40;
	localparam int PMC_FILT_CYC = (PMC_FILT_NS + PMC_CLK_NS - 1) / PMC_CLK_NS;
	typedef enum logic [1:0] {
		PMC_EDGE_NONE = 2'b00,
		PMC_EDGE_RISE = 2'b01,
		PMC_EDGE_FALL = 2'b10,
		PMC_EDGE_BOTH = 2'b11
	} pmc_edge_e;
endpackage : pmc_pkg

/* File: rtl/pmc_edge_filter.sv */
// Purpose: Noise elimination and edge detection for one alternate input
// Assumes: Input already synchronised to CLK_SYS_I
// Notes: A level must hold one cycle longer than the filter count before it is accepted
`timescale 1ns/1ps
`default_nettype none
module pmc_edge_filter (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sync_i,
	input wire logic [1:0] edge_sel_i,
	output logic level_o,
	output logic edge_o
);
	localparam logic [2:0] CNT_MAX = 3'(pmc_pkg::PMC_FILT_CYC);
	logic [2:0] cnt;
	logic level;
	logic edge_q;
	wire differs = sync_i != level;
	wire accept = differs && (cnt == CNT_MAX);
	wire rise_hit = accept && sync_i && edge_sel_i[0];
	wire fall_hit = accept && !sync_i && edge_sel_i[1];
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 3'h0;
			level <= 1'b0;
			edge_q <= 1'b0;
		end else begin
			cnt <= (differs && !accept) ? cnt + 3'h1 : 3'h0;
			level <= accept ? sync_i : level;
			edge_q <= rise_hit || fall_hit;
		end
	end
	assign level_o = level;
	assign edge_o = edge_q;
	// A glitch shorter than the filter count never moves the level
	glitch_reject_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(level != $past(level)) |-> $past(cnt) == CNT_MAX)
		else $error("filtered level moved before the filter count");
endmodule : pmc_edge_filter
`default_nettype wire

/* File: rtl/pmc_port0.sv */
// Purpose: Port 0 pin mode control with alternate functions
// Assumes: Byte bus with bit mask for single-bit writes
// Notes: Timer and interrupt sides receive filtered levels and edges
// Operation
// - Five pins, each independently input or output
// - Control mode gives timer, interrupt, DMA functions
// - Direction register plus mode and choice registers
// - Mode register takes byte and bit accesses
// - Bits 5,4 pick interrupt or DMA input
// - Bit 3 drives pin from timer output
// - Bit 2 routes pin to interrupt input
// - Bit 1 feeds interrupt and timer together
// - Choice bits 5,4 ignored in port mode
// - Read returns pin, latch or alternate output
`timescale 1ns/1ps
`default_nettype none
module pmc_port0 (
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	input wire logic [31:0] BUS_ADDR_I,
	input wire logic BUS_WR_I,
	input wire logic BUS_RD_I,
	input wire logic [7:0] BUS_BIT_MASK_I,
	input wire logic [7:0] BUS_WDATA_I,
	output logic [7:0] BUS_RDATA_O,
	input wire logic [7:0] PIN_IN_I,
	output logic [7:0] PIN_OUT_O,
	output logic [7:0] PIN_OE_O,
	input wire logic TIMER_PULSE_OUT_I,
	input wire logic [1:0] EDGE_SEL_I,
	output logic TIMER_PULSE_IN_O,
	output logic TIMER_PULSE_IN_EDGE_O,
	output logic EXT_IRQ_A0_O,
	output logic EXT_IRQ_A1_O,
	output logic EXT_IRQ_B0_O,
	output logic EXT_IRQ_B1_O,
	output logic DMA_REQUEST_0_O,
	output logic DMA_REQUEST_1_O
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] port0_function_select;
	logic [7:0] port0_alt_choice;
	logic [7:0] port0_direction;
	logic [7:0] port0_latch;
	logic [7:0] pin_meta;
	logic [7:0] pin_sync;
	logic [7:0] rdata;
	wire sel_fs = BUS_ADDR_I == pmc_pkg::PMC_ADDR_FUNC_SEL;
	wire sel_ac = BUS_ADDR_I == pmc_pkg::PMC_ADDR_ALT_CHOICE;
	wire sel_pd = BUS_ADDR_I == pmc_pkg::PMC_ADDR_PORT_DATA;
	wire sel_dir = BUS_ADDR_I == pmc_pkg::PMC_ADDR_DIRECTION;
	// Bit access is a masked write; byte access sets all mask bits
	wire [7:0] next_fs = ((port0_function_select & ~BUS_BIT_MASK_I)
		| (BUS_WDATA_I & BUS_BIT_MASK_I)) & pmc_pkg::PMC_FUNC_SEL_MASK;
	wire [7:0] next_ac = ((port0_alt_choice & ~BUS_BIT_MASK_I)
		| (BUS_WDATA_I & BUS_BIT_MASK_I)) & pmc_pkg::PMC_ALT_CHOICE_MASK;
	wire [7:0] next_dir = ((port0_direction & ~BUS_BIT_MASK_I)
		| (BUS_WDATA_I & BUS_BIT_MASK_I)) | ~pmc_pkg::PMC_PORT_MASK;
	wire [7:0] next_latch = ((port0_latch & ~BUS_BIT_MASK_I)
		| (BUS_WDATA_I & BUS_BIT_MASK_I)) & pmc_pkg::PMC_PORT_MASK;
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			port0_function_select <= pmc_pkg::PMC_FUNC_SEL_RST;
			port0_alt_choice <= pmc_pkg::PMC_ALT_CHOICE_RST;
			port0_direction <= pmc_pkg::PMC_DIRECTION_RST;
			port0_latch <= pmc_pkg::PMC_PORT_DATA_RST;
		end else begin
			if (BUS_WR_I && sel_fs)
				port0_function_select <= next_fs;
			if (BUS_WR_I && sel_ac)
				port0_alt_choice <= next_ac;
			if (BUS_WR_I && sel_dir)
				port0_direction <= next_dir;
			if (BUS_WR_I && sel_pd)
				port0_latch <= next_latch;
		end
	end
	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
		end else begin
			pin_meta <= PIN_IN_I;
			pin_sync <= pin_meta;
		end
	end
	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	wire [7:0] ctrl_en = port0_function_select;
	// Only pin 3 has an alternate output; other control-mode outputs stay low
	wire [7:0] alt_out = 8'(TIMER_PULSE_OUT_I) << pmc_pkg::PMC_BIT_TO;
	wire [7:0] out_mux = (alt_out & ctrl_en) | (port0_latch & ~ctrl_en);
	wire [7:0] out_en = ~port0_direction & pmc_pkg::PMC_PORT_MASK;
	// Data out is registered; latch is preloaded by software first
	logic [7:0] pin_out;
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I)
			pin_out <= 8'h00;
		else
			pin_out <= out_mux;
	end
	assign PIN_OUT_O = pin_out;
	assign PIN_OE_O = out_en;
	// ----------------------------------------
	// Alternate inputs
	// ----------------------------------------
	logic [7:0] filt_level;
	logic [7:0] filt_edge;
	genvar g;
	generate
		for (g = 1; g < 6; g++) begin : g_filt
			pmc_edge_filter u_filt (
				.clk_i(CLK_SYS_I),
				.rst_n_i(RST_N_I),
				.sync_i(pin_sync[g] & ctrl_en[g]),
				.edge_sel_i(EDGE_SEL_I),
				.level_o(filt_level[g]),
				.edge_o(filt_edge[g])
			);
		end
	endgenerate
	assign filt_level[0] = 1'b0;
	assign filt_edge[0] = 1'b0;
	assign filt_level[7:6] = 2'b00;
	assign filt_edge[7:6] = 2'b00;
	// Bit 1 feeds both consumers; software decides which one listens
	assign EXT_IRQ_A0_O = filt_edge[pmc_pkg::PMC_BIT_TI];
	assign TIMER_PULSE_IN_O = filt_level[pmc_pkg::PMC_BIT_TI];
	assign TIMER_PULSE_IN_EDGE_O = filt_edge[pmc_pkg::PMC_BIT_TI];
	assign EXT_IRQ_A1_O = filt_edge[pmc_pkg::PMC_BIT_IRQ_A1];
	wire dma_b0 = port0_alt_choice[pmc_pkg::PMC_BIT_B0];
	wire dma_b1 = port0_alt_choice[pmc_pkg::PMC_BIT_B1];
	assign EXT_IRQ_B0_O = filt_edge[pmc_pkg::PMC_BIT_B0] & ~dma_b0;
	assign EXT_IRQ_B1_O = filt_edge[pmc_pkg::PMC_BIT_B1] & ~dma_b1;
	assign DMA_REQUEST_0_O = filt_edge[pmc_pkg::PMC_BIT_B0] & dma_b0;
	assign DMA_REQUEST_1_O = filt_edge[pmc_pkg::PMC_BIT_B1] & dma_b1;
	// ----------------------------------------
	// Read path
	// ----------------------------------------
	wire [7:0] out_view = (alt_out & ctrl_en) | (port0_latch & ~ctrl_en);
	wire [7:0] port_view = ((pin_sync & port0_direction)
		| (out_view & ~port0_direction)) & pmc_pkg::PMC_PORT_MASK;
	wire [7:0] next_rdata = sel_fs ? port0_function_select
		: sel_ac ? port0_alt_choice
		: sel_dir ? port0_direction
		: sel_pd ? port_view : 8'h00;
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I)
			rdata <= 8'h00;
		else
			rdata <= BUS_RD_I ? next_rdata : rdata;
	end
	assign BUS_RDATA_O = rdata;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	reserved_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(port0_function_select & ~pmc_pkg::PMC_FUNC_SEL_MASK) == 8'h00)
		else $error("reserved mode bits set");
	byte_write_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(BUS_WR_I && sel_fs && BUS_BIT_MASK_I == 8'hff) |=>
		port0_function_select == ($past(BUS_WDATA_I) & pmc_pkg::PMC_FUNC_SEL_MASK))
		else $error("mode register byte write lost");
	timer_out_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		ctrl_en[pmc_pkg::PMC_BIT_TO] |=> PIN_OUT_O[pmc_pkg::PMC_BIT_TO]
		== $past(TIMER_PULSE_OUT_I))
		else $error("timer output not on pin 3");
	port_out_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		!ctrl_en[pmc_pkg::PMC_BIT_TO] |=> PIN_OUT_O[pmc_pkg::PMC_BIT_TO]
		== $past(port0_latch[pmc_pkg::PMC_BIT_TO]))
		else $error("latch not on pin 3");
	dma_excl_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		!(DMA_REQUEST_0_O && EXT_IRQ_B0_O))
		else $error("pin 4 drives dma and irq");
	shared_pin_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		EXT_IRQ_A0_O == TIMER_PULSE_IN_EDGE_O)
		else $error("shared pin consumers differ");
	port_mode_quiet_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(!ctrl_en[pmc_pkg::PMC_BIT_IRQ_A1])[*8] |-> !EXT_IRQ_A1_O)
		else $error("irq from pin in port mode");
	input_read_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(BUS_RD_I && sel_pd && port0_direction[pmc_pkg::PMC_BIT_TI])
		|=> BUS_RDATA_O[pmc_pkg::PMC_BIT_TI] == $past(pin_sync[pmc_pkg::PMC_BIT_TI]))
		else $error("input pin read wrong");
	unused_oe_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(PIN_OE_O & ~pmc_pkg::PMC_PORT_MASK) == 8'h00)
		else $error("absent pin driven");
	pin4_quiet_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(!ctrl_en[pmc_pkg::PMC_BIT_B0])[*8] |-> !(DMA_REQUEST_0_O || EXT_IRQ_B0_O))
		else $error("pin 4 request in port mode");
	pin5_quiet_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(!ctrl_en[pmc_pkg::PMC_BIT_B1])[*8] |-> !(DMA_REQUEST_1_O || EXT_IRQ_B1_O))
		else $error("pin 5 request in port mode");
	dma_route_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		DMA_REQUEST_1_O |-> port0_alt_choice[pmc_pkg::PMC_BIT_B1] && !EXT_IRQ_B1_O)
		else $error("pin 5 request on wrong output");
	// ----------------------------------------
	// Filter checks
	// ----------------------------------------
	// Pin 1 as its filter sees it; port mode forces it low
	wire pin1_in = pin_sync[pmc_pkg::PMC_BIT_TI] & ctrl_en[pmc_pkg::PMC_BIT_TI];
	sequence pin1_held_s;
		pin1_in[*4];
	endsequence
	sequence pin1_blip_s;
		!pin1_in ##1 pin1_in[*2] ##1 !pin1_in;
	endsequence
	filter_accept_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(!TIMER_PULSE_IN_O ##0 pin1_held_s) |=> TIMER_PULSE_IN_O)
		else $error("steady pin 1 level not accepted");
	filter_reject_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(!TIMER_PULSE_IN_O ##0 pin1_blip_s) |=> !TIMER_PULSE_IN_O)
		else $error("short pin 1 pulse passed the filter");
endmodule : pmc_port0
`default_nettype wire

/* File: verification/pmc_pin_model.sv */
// Purpose: External circuitry facing the five port pins
// Assumes: An undriven pin sits on a weak pull-down
// Notes: The port's own drive wins over the outside source
`timescale 1ns/1ps
`default_nettype none
module pmc_pin_model (
	input wire logic [7:0] pin_out_i,
	input wire logic [7:0] pin_oe_i,
	input wire logic [7:0] ext_drive_i,
	output logic [7:0] pin_level_o
);
	// ----------------------------------------
	// Wire level
	// ----------------------------------------
	// Only a high outside drive lifts an undriven pin, so no stale level lingers
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_level_o[i] = pin_oe_i[i] ? pin_out_i[i] : ext_drive_i[i];
		end
	end
endmodule : pmc_pin_model
`default_nettype wire

/* File: verification/pmc_port0_tb_top.sv */
// Purpose: Self-checking bench for the port 0 mode control block
// Assumes: Inputs change at the falling edge
// Notes: Timer control settings are software duties and are not modelled
`timescale 1ns/1ps
`default_nettype none
module pmc_port0_tb_top;
	logic clk, rst_n, wr, rd, tmr_out, ti, ti_edge;
	logic [31:0] addr;
	logic [7:0] mask, wdata, rdata, pin_in, pin_out, pin_oe, ext;
	logic [1:0] edge_sel;
	logic [5:0] hit;
	wire [5:0] irq;
	int err_total = 0;
	int samples_checked = 0;
	pmc_port0 DUT (.CLK_SYS_I(clk), .RST_N_I(rst_n), .BUS_ADDR_I(addr), .BUS_WR_I(wr),
		.BUS_RD_I(rd), .BUS_BIT_MASK_I(mask), .BUS_WDATA_I(wdata), .BUS_RDATA_O(rdata),
		.PIN_IN_I(pin_in), .PIN_OUT_O(pin_out), .PIN_OE_O(pin_oe),
		.TIMER_PULSE_OUT_I(tmr_out), .EDGE_SEL_I(edge_sel), .TIMER_PULSE_IN_O(ti),
		.TIMER_PULSE_IN_EDGE_O(ti_edge), .EXT_IRQ_A0_O(irq[0]), .EXT_IRQ_A1_O(irq[1]),
		.EXT_IRQ_B0_O(irq[2]), .EXT_IRQ_B1_O(irq[3]), .DMA_REQUEST_0_O(irq[4]),
		.DMA_REQUEST_1_O(irq[5]));
	pmc_pin_model pins (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_drive_i(ext),
		.pin_level_o(pin_in));
	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		give_verdict();
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [31:0] a, input logic [7:0] m, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		mask = m;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [31:0] a, input logic [7:0] exp);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk(rdata, exp);
	endtask : rd_reg
	// Filtered pulse on one pin; the set of alternate outputs that fired is compared
	task automatic scen(input logic [7:0] md, input logic [7:0] ch, input int b, input int len,
		input logic [5:0] exp);
		logic tie;
		wr_reg(pmc_pkg::PMC_ADDR_FUNC_SEL, 8'hff, md);
		wr_reg(pmc_pkg::PMC_ADDR_ALT_CHOICE, 8'hff, ch);
		hit = 6'h00;
		tie = 1'b0;
		ext[b] = 1'b1;
		// One-cycle pulses are collected at every falling edge while they stand
		for (int i = 0; i < len + 14; i++) begin
			@(negedge clk);
			hit = hit | irq;
			tie = tie | ti_edge;
			if (i == len - 1) begin
				if (b == 1 && len > 4 && md[1]) chk({7'h00, ti}, 8'h01);
				ext[b] = 1'b0;
			end
		end
		chk({2'b00, hit}, {2'b00, exp});
		chk({7'h00, tie}, {7'h00, exp[0]});
	endtask : scen
	task automatic give_verdict;
		if (err_total == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		{wr, rd, tmr_out, addr, mask, wdata, ext, hit} = '0;
		edge_sel = 2'b01;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		rd_reg(pmc_pkg::PMC_ADDR_FUNC_SEL, 8'h00);
		rd_reg(pmc_pkg::PMC_ADDR_ALT_CHOICE, 8'h00);
		rd_reg(pmc_pkg::PMC_ADDR_DIRECTION, 8'hff);
		wr_reg(pmc_pkg::PMC_ADDR_FUNC_SEL, 8'hff, 8'hff);
		rd_reg(pmc_pkg::PMC_ADDR_FUNC_SEL, 8'h3e);
		wr_reg(pmc_pkg::PMC_ADDR_FUNC_SEL, 8'h08, 8'h00);
		rd_reg(pmc_pkg::PMC_ADDR_FUNC_SEL, 8'h36);
		wr_reg(pmc_pkg::PMC_ADDR_FUNC_SEL, 8'hff, 8'h00);
		wr_reg(32'hffff_f444, 8'hff, 8'hff);
		rd_reg(32'hffff_f444, 8'h00);
		ext = 8'h04;
		repeat (3) @(negedge clk);
		rd_reg(pmc_pkg::PMC_ADDR_PORT_DATA, 8'h04);
		ext = 8'h00;
		wr_reg(pmc_pkg::PMC_ADDR_PORT_DATA, 8'hff, 8'h08);
		wr_reg(pmc_pkg::PMC_ADDR_DIRECTION, 8'hff, 8'hf7);
		chk(pin_oe, 8'h08);
		rd_reg(pmc_pkg::PMC_ADDR_PORT_DATA, 8'h08);
		// Inactive level goes into the latch before the pin is handed to the timer
		wr_reg(pmc_pkg::PMC_ADDR_PORT_DATA, 8'hff, 8'h00);
		wr_reg(pmc_pkg::PMC_ADDR_FUNC_SEL, 8'h08, 8'h08);
		tmr_out = 1'b1;
		repeat (2) @(negedge clk);
		chk(pin_out, 8'h08);
		rd_reg(pmc_pkg::PMC_ADDR_PORT_DATA, 8'h08);
		tmr_out = 1'b0;
		repeat (2) @(negedge clk);
		chk(pin_out, 8'h00);
		wr_reg(pmc_pkg::PMC_ADDR_DIRECTION, 8'hff, 8'hff);
		// EXT_IRQ_A0_O fires together with the timer edge while pin 1 serves the timer
		scen(8'h00, 8'h00, 1, 8, 6'h00);
		scen(8'h3e, 8'h00, 1, 2, 6'h00);
		scen(8'h3e, 8'h00, 1, 8, 6'h01);
		scen(8'h3e, 8'h00, 2, 8, 6'h02);
		scen(8'h3e, 8'h00, 4, 8, 6'h04);
		scen(8'h3e, 8'h00, 5, 8, 6'h08);
		scen(8'h3e, 8'h30, 4, 8, 6'h10);
		scen(8'h3e, 8'h30, 5, 8, 6'h20);
		scen(8'h00, 8'h30, 4, 8, 6'h00);
		// Falling-edge select: only the release of the pin may raise a request
		edge_sel = 2'b10;
		scen(8'h3e, 8'h00, 2, 8, 6'h02);
		wr_reg(pmc_pkg::PMC_ADDR_DIRECTION, 8'hff, 8'hf7);
		chk(pin_oe, 8'h08);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		chk(pin_oe, 8'h00);
		rd_reg(pmc_pkg::PMC_ADDR_FUNC_SEL, 8'h00);
		rd_reg(pmc_pkg::PMC_ADDR_DIRECTION, 8'hff);
		give_verdict();
	end
endmodule : pmc_port0_tb_top
`default_nettype wire
